// File: hw/qctx_pkg.sv
// Constants for the queue command and transmit pointer block
`default_nettype none
package qctx_pkg;
  // ------------------------------------------------------------
  // Register offsets (byte addresses on the host bus)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_TX_COMMAND = 8'h80;
  localparam logic [7:0] OFF_RX_QUEUE_COMMAND = 8'h82;
  localparam logic [7:0] OFF_TX_FRAME_DATA_POINTER = 8'h84;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int RXQ_DUR_STATUS_BIT = 12;
  localparam int RXQ_BYTE_STATUS_BIT = 11;
  localparam int RXQ_FRAME_STATUS_BIT = 10;
  localparam int RXQ_IP_OFFSET_BIT = 9;
  localparam int RXQ_DUR_EN_BIT = 7;
  localparam int RXQ_BYTE_EN_BIT = 6;
  localparam int RXQ_FRAME_EN_BIT = 5;
  localparam int RXQ_AUTO_DEQ_BIT = 4;
  localparam int RXQ_DMA_START_BIT = 3;
  localparam int RXQ_RELEASE_BIT = 0;
  localparam int TXP_AUTO_INC_BIT = 14;
  localparam int TXQ_MANUAL_ENQ_BIT = 0;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_BE_LSB = 12;

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int TX_PTR_W = 11;
  localparam logic [10:0] TX_PTR_RESET = 11'h000;
  localparam logic [10:0] STEP_BYTE = 11'h001;
  localparam logic [10:0] STEP_WORD = 11'h002;
  localparam logic [10:0] STEP_DWORD = 11'h004;
  localparam logic [15:0] DUR_MAX = 16'hffff;

  // ------------------------------------------------------------
  // Timing: microsecond tick for the duration timer
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);
endpackage
`default_nettype wire

// File: hw/qctx_ptr_step.sv
// Pointer advance derived from the byte enables of one access
`default_nettype none
module qctx_ptr_step (
  input wire logic [3:0] be,
  output logic [qctx_pkg::TX_PTR_W-1:0] step
);
  import qctx_pkg::*;
  logic [2:0] cnt;

  always_comb begin
    cnt = 3'(be[0]) + 3'(be[1]) + 3'(be[2]) + 3'(be[3]);
    case (cnt)
      3'h1: step = STEP_BYTE; // see [RULE11]
      3'h2: step = STEP_WORD; // see [RULE11]
      3'h4: step = STEP_DWORD; // see [RULE11]
      default: step = '0;
    endcase
  end
endmodule
`default_nettype wire

// File: hw/qctx_top.sv
// Receive queue command and transmit frame pointer control
`default_nettype none
// What this block does
// [RULE1] Duration threshold enabled: raise receive interrupt when elapsed time exceeds threshold.
// [RULE2] Byte count threshold enabled: raise receive interrupt when queued bytes exceed it.
// [RULE3] Frame count threshold enabled: raise receive interrupt when queued frames exceed it.
// [RULE4] Auto-dequeue enabled: advance to next frame once current frame fully read.
// [RULE5] Writing DMA start lets host stream queue data with command-select low.
// [RULE6] In DMA mode all registers except receive queue command are blocked.
// [RULE7] Host ends DMA by writing with command-select high before other registers.
// [RULE8] Release-error-frame bit frees the error frame, self-clears when memory released.
// [RULE9] Host waits for release bit to read cleared before the next frame.
// [RULE10] Auto-increment set: transmit pointer advances on each frame data access.
// [RULE11] Advance equals access width: one, two or four.
// [RULE12] Auto-increment clear: pointer stays, host controls location manually; here pointer register writes set only auto-increment.
// [RULE13] Pointer field reloads with next free location after a frame is enqueued.
// [RULE14] Threshold status flags refresh when host writes one to interrupt bit 13.
// [RULE15] Manual enqueue bit queues one prepared frame, self-clears after sending.
// [RULE16] Host resets receive pointer to zero before each receive DMA read.
// [RULE17] Advance only on DMA frame data accesses; pointer wraps modulo eleven bits.
module qctx_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic cmd_select,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  input wire logic [15:0] rx_frame_count,
  input wire logic [15:0] rx_byte_count,
  input wire logic [15:0] duration_threshold,
  input wire logic [15:0] byte_count_threshold,
  input wire logic [15:0] frame_count_threshold,
  input wire logic isr_rx_write_one,
  output logic rx_interrupt,
  input wire logic rx_frame_read_done,
  output logic rx_dequeue,
  output logic release_error_frame,
  input wire logic rx_release_done,
  output logic rx_ip_offset,
  output logic dma_active,
  output logic queue_rd,
  output logic queue_wr,
  output logic [15:0] queue_wdata,
  input wire logic [15:0] queue_rdata,
  output logic [3:0] queue_be,
  output logic [qctx_pkg::TX_PTR_W-1:0] tx_frame_pointer,
  output logic manual_enqueue,
  input wire logic tx_sent,
  input wire logic tx_enqueued,
  input wire logic [qctx_pkg::TX_PTR_W-1:0] tx_next_free
);
  import qctx_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] be;
    logic acc_prev;
    logic rd_drive;
    logic [15:0] rdata;
    logic dma;
    logic dur_en;
    logic byte_en;
    logic frame_en;
    logic auto_deq;
    logic ip_off;
    logic release_req;
    logic [2:0] status;
    logic [2:0] cond_prev;
    logic irq;
    logic deq;
    logic [7:0] us_div;
    logic [15:0] dur;
    logic auto_inc;
    logic [TX_PTR_W-1:0] tx_ptr;
    logic man_enq;
    logic qrd;
    logic qwr;
    logic [15:0] qwdata;
  } qctx_state_t;

  qctx_state_t st_r;
  qctx_state_t st_nxt;
  logic [TX_PTR_W-1:0] step;
  logic acc;
  logic start;
  logic is_wr;
  logic [2:0] hit;
  logic [2:0] cond;

  qctx_ptr_step u_step (
    .be(st_r.be),
    .step(step)
  );

  // ------------------------------------------------------------
  // Access detection and threshold compare
  // ------------------------------------------------------------
  assign acc = !chip_select_n && (!read_strobe_n || !write_strobe_n);
  assign start = acc && !st_r.acc_prev;
  assign is_wr = !write_strobe_n;
  assign hit[2] = st_r.dur > duration_threshold; // see [RULE1]
  assign hit[1] = rx_byte_count > byte_count_threshold; // see [RULE2]
  assign hit[0] = rx_frame_count > frame_count_threshold; // see [RULE3]
  assign cond = hit & {st_r.dur_en, st_r.byte_en, st_r.frame_en};

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.acc_prev = acc;
    st_nxt.qrd = 1'b0;
    st_nxt.qwr = 1'b0;
    st_nxt.deq = 1'b0;
    st_nxt.rd_drive = acc && !read_strobe_n && !cmd_select;
    // Microsecond timer runs while frames wait in the queue
    if (rx_frame_count == 16'h0000) begin
      st_nxt.us_div = '0;
      st_nxt.dur = '0;
    end else if (st_r.us_div == US_LAST) begin
      st_nxt.us_div = '0;
      if (st_r.dur != DUR_MAX) begin
        st_nxt.dur = st_r.dur + 16'h0001;
      end
    end else begin
      st_nxt.us_div = st_r.us_div + 8'h01;
    end
    // Interrupt on a newly met enabled condition
    st_nxt.cond_prev = cond;
    st_nxt.irq = |(cond & ~st_r.cond_prev); // see [RULE1] [RULE2] [RULE3]
    if (isr_rx_write_one) begin
      st_nxt.status = hit; // see [RULE14]
    end
    if (rx_frame_read_done && st_r.auto_deq) begin
      st_nxt.deq = 1'b1; // see [RULE4]
    end
    // Hardware clears; a host write below still wins
    if (rx_release_done) begin
      st_nxt.release_req = 1'b0; // see [RULE8]
    end
    if (tx_sent) begin
      st_nxt.man_enq = 1'b0; // see [RULE15]
    end
    if (start && cmd_select && is_wr) begin
      // Command phase: address and byte enables
      if (!st_r.dma || data_in[7:0] == OFF_RX_QUEUE_COMMAND) begin // see [RULE6]
        st_nxt.addr = data_in[CMD_ADDR_LSB +: 8];
        st_nxt.be = data_in[CMD_BE_LSB +: 4];
        st_nxt.dma = 1'b0; // see [RULE7]
      end
    end else if (start && !cmd_select && st_r.dma) begin
      // Frame data access in DMA mode
      st_nxt.qrd = !is_wr; // see [RULE5]
      st_nxt.qwr = is_wr; // see [RULE5]
      st_nxt.qwdata = data_in;
      if (!is_wr) begin
        st_nxt.rdata = queue_rdata;
      end
      if (st_r.auto_inc) begin
        st_nxt.tx_ptr = st_r.tx_ptr + step; // see [RULE10] [RULE11] [RULE17]
      end
    end else if (start && !cmd_select && is_wr) begin
      if (st_r.addr == OFF_RX_QUEUE_COMMAND) begin
        st_nxt.ip_off = data_in[RXQ_IP_OFFSET_BIT];
        st_nxt.dur_en = data_in[RXQ_DUR_EN_BIT];
        st_nxt.byte_en = data_in[RXQ_BYTE_EN_BIT];
        st_nxt.frame_en = data_in[RXQ_FRAME_EN_BIT];
        st_nxt.auto_deq = data_in[RXQ_AUTO_DEQ_BIT];
        st_nxt.dma = data_in[RXQ_DMA_START_BIT]; // see [RULE5]
        if (data_in[RXQ_RELEASE_BIT]) begin
          st_nxt.release_req = 1'b1; // see [RULE8]
        end
      end else if (st_r.addr == OFF_TX_FRAME_DATA_POINTER) begin
        st_nxt.auto_inc = data_in[TXP_AUTO_INC_BIT]; // see [RULE12]
      end else if (st_r.addr == OFF_TX_COMMAND) begin
        if (data_in[TXQ_MANUAL_ENQ_BIT]) begin
          st_nxt.man_enq = 1'b1; // see [RULE15]
        end
      end
    end else if (start && !cmd_select) begin
      // Register read
      st_nxt.rdata = '0;
      if (st_r.addr == OFF_RX_QUEUE_COMMAND) begin
        st_nxt.rdata[RXQ_DUR_STATUS_BIT] = st_r.status[2];
        st_nxt.rdata[RXQ_BYTE_STATUS_BIT] = st_r.status[1];
        st_nxt.rdata[RXQ_FRAME_STATUS_BIT] = st_r.status[0];
        st_nxt.rdata[RXQ_IP_OFFSET_BIT] = st_r.ip_off;
        st_nxt.rdata[RXQ_DUR_EN_BIT] = st_r.dur_en;
        st_nxt.rdata[RXQ_BYTE_EN_BIT] = st_r.byte_en;
        st_nxt.rdata[RXQ_FRAME_EN_BIT] = st_r.frame_en;
        st_nxt.rdata[RXQ_AUTO_DEQ_BIT] = st_r.auto_deq;
        st_nxt.rdata[RXQ_RELEASE_BIT] = st_r.release_req;
      end else if (st_r.addr == OFF_TX_FRAME_DATA_POINTER) begin
        st_nxt.rdata[TXP_AUTO_INC_BIT] = st_r.auto_inc;
        st_nxt.rdata[TX_PTR_W-1:0] = st_r.tx_ptr;
      end else if (st_r.addr == OFF_TX_COMMAND) begin
        st_nxt.rdata[TXQ_MANUAL_ENQ_BIT] = st_r.man_enq;
      end
    end
    // Enqueue reload overrides any advance in the same cycle
    if (tx_enqueued) begin
      st_nxt.tx_ptr = tx_next_free; // see [RULE13]
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign data_out = st_r.rdata;
  assign data_oe_n = !(st_r.rd_drive && acc && !read_strobe_n);
  assign rx_interrupt = st_r.irq;
  assign rx_dequeue = st_r.deq;
  assign release_error_frame = st_r.release_req;
  assign rx_ip_offset = st_r.ip_off;
  assign dma_active = st_r.dma;
  assign queue_rd = st_r.qrd;
  assign queue_wr = st_r.qwr;
  assign queue_wdata = st_r.qwdata;
  assign queue_be = st_r.be;
  assign tx_frame_pointer = st_r.tx_ptr;
  assign manual_enqueue = st_r.man_enq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic dma_data;
  logic reg_wr;
  assign dma_data = start && !cmd_select && st_r.dma;
  assign reg_wr = start && !cmd_select && is_wr && !st_r.dma;

  sequence s_new_hit(int idx);
    cond[idx] && !st_r.cond_prev[idx];
  endsequence

  sequence s_rxq_write(int bitpos);
    reg_wr && st_r.addr == OFF_RX_QUEUE_COMMAND && data_in[bitpos];
  endsequence

  dur_irq_a: assert property (s_new_hit(2) |=> rx_interrupt) // see [RULE1]
    else $error("duration threshold did not raise the interrupt");
  byte_irq_a: assert property (s_new_hit(1) |=> rx_interrupt) // see [RULE2]
    else $error("byte threshold did not raise the interrupt");
  frame_irq_a: assert property (s_new_hit(0) |=> rx_interrupt) // see [RULE3]
    else $error("frame threshold did not raise the interrupt");
  auto_deq_a: assert property (rx_frame_read_done |=> rx_dequeue == $past(st_r.auto_deq)) // see [RULE4]
    else $error("dequeue pulse does not follow auto-dequeue");
  dma_enter_a: assert property (s_rxq_write(RXQ_DMA_START_BIT) |=> dma_active) // see [RULE5]
    else $error("DMA mode not entered");
  dma_block_a: assert property (st_r.dma && start && cmd_select && is_wr
      && data_in[7:0] != OFF_RX_QUEUE_COMMAND |=> $stable(st_r.addr) && dma_active) // see [RULE6]
    else $error("register access not blocked in DMA mode");
  release_set_a: assert property (s_rxq_write(RXQ_RELEASE_BIT) |=> release_error_frame) // see [RULE8]
    else $error("release bit lost");
  release_clr_a: assert property (rx_release_done && !reg_wr |=> !release_error_frame) // see [RULE8]
    else $error("release bit did not self-clear");
  ptr_step_a: assert property (dma_data && st_r.auto_inc && !tx_enqueued
      |=> tx_frame_pointer == $past(st_r.tx_ptr) + $past(step)) // see [RULE10] [RULE11]
    else $error("pointer advance wrong");
  ptr_hold_a: assert property ((!st_r.auto_inc || !dma_data) && !tx_enqueued
      |=> $stable(tx_frame_pointer)) // see [RULE12] [RULE17]
    else $error("pointer moved without auto-increment access");
  ptr_reload_a: assert property (tx_enqueued |=> tx_frame_pointer == $past(tx_next_free)) // see [RULE13]
    else $error("pointer not reloaded after enqueue");
  status_a: assert property (isr_rx_write_one |=> st_r.status == $past(hit)) // see [RULE14]
    else $error("threshold status not refreshed");
  enq_clr_a: assert property (tx_sent && !reg_wr |=> !manual_enqueue) // see [RULE15]
    else $error("manual enqueue did not self-clear");

  sequence s_read_start;
    start && !read_strobe_n && !cmd_select;
  endsequence

  dma_exit_a: assert property (start && cmd_select && is_wr // see [RULE7]
      && data_in[7:0] == OFF_RX_QUEUE_COMMAND |=> !dma_active)
    else $error("command write did not leave DMA mode");
  q_write_a: assert property (dma_data && is_wr |=> queue_wr) // see [RULE5]
    else $error("queue write strobe missing");
  q_wdata_a: assert property (queue_wr |-> queue_wdata == $past(data_in)) // see [RULE5]
    else $error("queue write data wrong");
  q_read_a: assert property (dma_data && !is_wr |=> queue_rd) // see [RULE5]
    else $error("queue read strobe missing");
  q_rdata_a: assert property (queue_rd |-> data_out == $past(queue_rdata)) // see [RULE5]
    else $error("queue read data wrong");
  reg_block_a: assert property (dma_data |=> $stable({rx_ip_offset, dma_active})) // see [RULE6]
    else $error("data access in DMA mode touched a register");
  oe_read_a: assert property (s_read_start ##1 (acc && !read_strobe_n) // see [RULE5]
      |-> !data_oe_n)
    else $error("read data not driven");
  oe_idle_a: assert property (!acc |-> data_oe_n) // see [RULE5]
    else $error("data driven outside an access");
endmodule
`default_nettype wire

// File: test/qctx_host.sv
// Host processor model driving the parallel register and data bus
`default_nettype none
module qctx_host (
  input wire logic clk,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic cmd_select,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {chip_select_n, read_strobe_n, write_strobe_n, cmd_select} = 4'hf;
    data_in = 16'h0000;
  end
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Held three edges, then a released cycle; idle data shows the inverse
  task automatic acc(input logic c, input logic w, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk);
    chip_select_n <= 1'b0;
    write_strobe_n <= !w;
    read_strobe_n <= w;
    cmd_select <= c;
    data_in <= d;
    repeat (3) @(posedge clk);
    q = data_out;
    {chip_select_n, read_strobe_n, write_strobe_n} <= 3'h7;
    data_in <= ~d;
  endtask
  // Command write carries offset and byte enables, then the data phase
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be = 4'h0);
    logic [15:0] q;
    acc(1'b1, 1'b1, {be, 4'h0, a}, q);
    acc(1'b0, 1'b1, d, q);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] q);
    acc(1'b1, 1'b1, {8'h00, a}, q);
    acc(1'b0, 1'b0, 16'h0000, q);
  endtask
endmodule
`default_nettype wire

// File: test/test_queue_command_and_tx_pointer.sv
// Self-checking bench for the queue command and transmit pointer block
`default_nettype none
module test_queue_command_and_tx_pointer;
  timeunit 1ns;
  timeprecision 1ps;
  import qctx_pkg::*;
  logic clk, reset_n, chip_select_n, read_strobe_n, write_strobe_n, cmd_select;
  logic [15:0] data_in, data_out, rx_frame_count, rx_byte_count, duration_threshold;
  logic [15:0] byte_count_threshold, frame_count_threshold, queue_wdata, queue_rdata, q, last_w;
  logic data_oe_n, isr_rx_write_one, rx_interrupt, rx_frame_read_done, rx_dequeue;
  logic release_error_frame, rx_release_done, rx_ip_offset, dma_active, queue_rd, queue_wr;
  logic manual_enqueue, tx_sent, tx_enqueued;
  logic [3:0] queue_be;
  logic [10:0] tx_frame_pointer, tx_next_free, e;
  logic [4:0] pv;
  int bad_count, cmp_count, irq_n, deq_n, qw_n, qr_n, oe_cnt;
  assign {tx_enqueued, tx_sent, rx_release_done, rx_frame_read_done, isr_rx_write_one} = pv;
  qctx_top u_qctx_top (
    .clk, .reset_n, .chip_select_n, .read_strobe_n, .write_strobe_n, .cmd_select, .data_in,
    .data_out, .data_oe_n, .rx_frame_count, .rx_byte_count, .duration_threshold,
    .byte_count_threshold, .frame_count_threshold, .isr_rx_write_one, .rx_interrupt,
    .rx_frame_read_done, .rx_dequeue, .release_error_frame, .rx_release_done, .rx_ip_offset,
    .dma_active, .queue_rd, .queue_wr, .queue_wdata, .queue_rdata, .queue_be,
    .tx_frame_pointer, .manual_enqueue, .tx_sent, .tx_enqueued, .tx_next_free
  );
  qctx_host u_host (
    .clk, .chip_select_n, .read_strobe_n, .write_strobe_n, .cmd_select, .data_in, .data_out
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pulse counters for one-cycle outputs, plus a count of the cycles with data_oe_n low
  always @(posedge clk) begin
    if (rx_interrupt === 1'b1) irq_n++;
    if (rx_dequeue === 1'b1) deq_n++;
    if (queue_rd === 1'b1) qr_n++;
    if (queue_wr === 1'b1) qw_n++;
    if (queue_wr === 1'b1) last_w = queue_wdata;
    if (data_oe_n === 1'b0) oe_cnt++;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic pls(input logic [4:0] s);
    @(posedge clk);
    pv <= s;
    @(posedge clk);
    pv <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk(16'(tx_frame_pointer), 16'h0000);
    chk({15'h0, dma_active}, 16'h0000);
    chk({15'h0, data_oe_n}, 16'h0001);
    u_host.reg_rd(8'h84, q);
    chk(q, 16'h0000);
    u_host.reg_wr(8'h82, 16'h0270);
    u_host.reg_rd(8'h82, q);
    chk(q, 16'h0270);
    chk({15'h0, rx_ip_offset}, 16'h0001);
    u_host.reg_rd(8'h88, q);
    chk(q, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_thr;
    int n;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      duration_threshold <= 16'hffff;
      frame_count_threshold <= 16'h0003;
      byte_count_threshold <= 16'h0040;
      u_host.reg_wr(8'h82, i == 0 ? 16'h0020 : 16'h0040);
      n = irq_n;
      rx_frame_count <= i == 0 ? 16'h0003 : 16'h0000;
      rx_byte_count <= i == 0 ? 16'h0000 : 16'h0040;
      repeat (20) @(posedge clk);
      chk(16'(irq_n - n), 16'h0000);
      rx_frame_count <= i == 0 ? 16'h0004 : 16'h0000;
      rx_byte_count <= i == 0 ? 16'h0000 : 16'h0041;
      repeat (20) @(posedge clk);
      chk(16'(irq_n - n), 16'h0001);
      pls(5'h01);
      u_host.reg_rd(8'h82, q);
      chk(q & 16'h1c00, i == 0 ? 16'h0400 : 16'h0800);
      {rx_frame_count, rx_byte_count} <= 32'h0;
      pls(5'h01);
    end
    $display("count threshold test done");
  endtask
  task automatic t_dur;
    int n, c;
    @(posedge clk);
    duration_threshold <= 16'h0002;
    u_host.reg_wr(8'h82, 16'h0080);
    n = irq_n;
    rx_frame_count <= 16'h0001;
    for (c = 0; c < 1000 && irq_n == n; c++) @(posedge clk);
    // Two microseconds are exceeded once the third one has elapsed
    chk(16'(c > 3 * US_CYCLES && c < 3 * US_CYCLES + 5), 16'h0001);
    if (c == 1000) end_of_test;
    rx_frame_count <= 16'h0000;
    $display("duration test done");
  endtask
  task automatic t_rel;
    u_host.reg_wr(8'h82, 16'h0001);
    chk({15'h0, release_error_frame}, 16'h0001);
    u_host.reg_rd(8'h82, q);
    chk(q & 16'h0001, 16'h0001);
    pls(5'h04);
    for (int c = 0; c < 20 && q[0] !== 1'b0; c++) u_host.reg_rd(8'h82, q);
    chk(q & 16'h0001, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      u_host.reg_wr(8'h82, i == 0 ? 16'h0010 : 16'h0000);
      e = 11'(deq_n);
      pls(5'h02);
      chk(16'(deq_n - int'(e)), i == 0 ? 16'h0001 : 16'h0000);
    end
    $display("release and dequeue test done");
  endtask
  task automatic t_dma;
    logic [3:0] be;
    logic [10:0] st;
    int w, r, k;
    tx_next_free <= 11'h7fe;
    pls(5'h10);
    chk(16'(tx_frame_pointer), 16'h07fe);
    u_host.reg_wr(8'h84, 16'h4000);
    u_host.reg_rd(8'h84, q);
    chk(q, 16'h47fe);
    e = 11'h7fe;
    for (int i = 0; i < 4; i++) begin
      be = i == 0 ? 4'h1 : i == 1 ? 4'h3 : 4'hf;
      st = i == 0 ? 11'h001 : i == 1 ? 11'h002 : i == 2 ? 11'h004 : 11'h000;
      if (i == 3) u_host.reg_wr(8'h84, 16'h0000);
      u_host.reg_wr(8'h86, 16'h0000);
      u_host.reg_wr(8'h82, 16'h0008, be);
      u_host.acc(1'b1, 1'b1, {be, 12'h084}, q);
      chk({15'h0, dma_active}, 16'h0001);
      chk({12'h0, queue_be}, {12'h0, be});
      w = qw_n;
      r = qr_n;
      queue_rdata <= 16'h3c00 + 16'(i);
      u_host.acc(1'b0, 1'b1, 16'ha500 + 16'(i), q);
      e = e + st;
      chk(16'(tx_frame_pointer), 16'(e));
      chk(last_w, 16'ha500 + 16'(i));
      k = oe_cnt;
      u_host.acc(1'b0, 1'b0, 16'h0000, q);
      // One idle edge so the last driven cycle is counted
      @(posedge clk);
      e = e + st;
      chk(q, 16'h3c00 + 16'(i));
      chk(16'(oe_cnt - k), 16'h0002);
      chk({15'h0, data_oe_n}, 16'h0001);
      chk(16'(tx_frame_pointer), 16'(e));
      chk(16'(qw_n - w + 2 * (qr_n - r)), 16'h0003);
      u_host.reg_wr(8'h82, 16'h0000);
      chk({15'h0, dma_active}, 16'h0000);
    end
    u_host.reg_wr(8'h80, 16'h0001);
    chk({15'h0, manual_enqueue}, 16'h0001);
    u_host.reg_rd(8'h80, q);
    chk(q, 16'h0001);
    pls(5'h08);
    chk({15'h0, manual_enqueue}, 16'h0000);
    $display("pointer, data mode and enqueue test done");
  endtask
  initial begin
    reset_n = 1'b0;
    {rx_frame_count, rx_byte_count, duration_threshold} = 48'h0;
    {byte_count_threshold, frame_count_threshold, queue_rdata} = 48'h0;
    pv = 5'h00;
    tx_next_free = 11'h000;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_thr;
    t_dur;
    t_rel;
    t_dma;
    end_of_test;
  end
endmodule
`default_nettype wire
